//--- logic/uart_pins_map.svh
`ifndef UART_PINS_MAP_SVH
`define UART_PINS_MAP_SVH

// Modem status register fields
`define MSR_DCTS_BIT  0
`define MSR_DDSR_BIT  1
`define MSR_DDCD_BIT  3
`define MSR_CTS_BIT   4
`define MSR_DSR_BIT   5
`define MSR_DCD_BIT   7
// Modem control register fields
`define MCTL_DTR_BIT   0
`define MCTL_USER1_BIT 2
`define MCTL_USER2_BIT 3
`define MCTL_LOOP_BIT  4
`define MCTL_RESET     8'h00
`define MSR_RESET     8'h00
`endif

//--- logic/uart_pins_pkg.sv
package uart_pins_pkg;
   // Modem line levels as seen on the pins (active low lines)
   typedef struct packed {
      logic dcd_n;
      logic dsr_n;
      logic cts_n;
   } modem_in_type;

   // Pending interrupt sources from the UART core
   typedef struct packed {
      logic rx_error;
      logic rx_data;
      logic rx_timeout;
      logic thr_empty;
   } irq_src_type;

   // Latched host selection
   typedef struct packed {
      logic [2:0] addr;
      logic       sel;
   } host_sel_type;
endpackage

//--- logic/uart_host_modem_pins.sv
`timescale 1ns/1ps
`include "uart_pins_map.svh"
module uart_host_modem_pins
   import uart_pins_pkg::*;
(
   input  wire logic         clk_i,
   input  wire logic         reset_i,
   input  wire logic         unit_select_first_i,
   input  wire logic         unit_select_second_i,
   input  wire logic         unit_select_third_low_i,
   input  wire logic         address_latch_strobe_n_i,
   input  wire logic [2:0]   reg_addr_i,
   input  wire logic         host_read_i,
   input  wire logic         msr_read_i,
   input  wire logic [7:0]   read_data_i,
   input  wire logic [7:0]   host_data_bus_i,
   input  wire logic [7:0]   modem_control_reg_i,
   input  wire logic         modem_irq_enable_i,
   input  wire logic         auto_cts_enable_i,
   input  wire irq_src_type  irq_src_i,
   input  wire modem_in_type modem_in_i,
   output logic              selected_o,
   output logic [2:0]        sel_addr_o,
   output logic [7:0]        host_data_bus_o,
   output logic              host_data_bus_oe_n_o,
   output logic              transceiver_disable_out_o,
   output logic [7:0]        modem_status_o,
   output logic              tx_enable_o,
   output logic              irq_o,
   output logic              dtr_n_o,
   output logic              user_output_first_n_o,
   output logic              user_output_second_n_o
);

   // Chip select decode
   function automatic logic sel_decode(input logic a, input logic b, input logic c_n);
      sel_decode = a & b & ~c_n;
   endfunction

   modem_in_type sync1_q;
   modem_in_type sync2_q;
   modem_in_type prev_q;
   logic         strobe1_q;
   logic         strobe2_q;
   host_sel_type held_q;
   host_sel_type live_sel;
   logic [2:0]   delta_q;
   logic [2:0]   change;
   logic [2:0]   cs_sync1_q;
   logic [2:0]   cs_sync2_q;
   logic [2:0]   addr_sync1_q;
   logic [2:0]   addr_sync2_q;

   // Two-stage synchronisers; only stage two feeds logic
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         sync1_q   <= 3'b111;
         sync2_q   <= 3'b111;
         prev_q    <= 3'b111;
         strobe1_q <= 1'b1;
         strobe2_q <= 1'b1;
      end else begin
         sync1_q   <= modem_in_i;
         sync2_q   <= sync1_q;
         prev_q    <= sync2_q;
         strobe1_q <= address_latch_strobe_n_i;
         strobe2_q <= strobe1_q;
      end
   end

   // Host select pins are asynchronous too; synced on the same two stages as
   // the strobe so a select change and a strobe edge never slip past each other
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         cs_sync1_q   <= 3'b001;
         cs_sync2_q   <= 3'b001;
         addr_sync1_q <= 3'h0;
         addr_sync2_q <= 3'h0;
      end else begin
         cs_sync1_q   <= {unit_select_first_i, unit_select_second_i, unit_select_third_low_i};
         cs_sync2_q   <= cs_sync1_q;
         addr_sync1_q <= reg_addr_i;
         addr_sync2_q <= addr_sync1_q;
      end
   end

   // Edge of each modem line between stage two and the previous sample
   assign change = sync2_q ^ prev_q;
   // Decode only synced levels; decoding raw pins could glitch a selection
   assign live_sel.sel  = sel_decode(cs_sync2_q[2], cs_sync2_q[1], cs_sync2_q[0]);
   assign live_sel.addr = addr_sync2_q;

   // Selection follows pins while strobe low, frozen while high
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         held_q     <= '0;
         selected_o <= 1'b0;
         sel_addr_o <= 3'h0;
      end else if (!strobe2_q) begin
         held_q     <= live_sel;
         selected_o <= live_sel.sel;
         sel_addr_o <= live_sel.addr;
      end else begin
         selected_o <= held_q.sel;
         sel_addr_o <= held_q.addr;
      end
   end

   // Delta bits: set wins over read-clear so no edge is lost
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         delta_q <= 3'b000;
      end else begin
         delta_q <= (msr_read_i ? 3'b000 : delta_q) | change;
      end
   end

   // Status byte: inverted pin levels, deltas in low nibble
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         modem_status_o <= `MSR_RESET;
      end else begin
         modem_status_o <= `MSR_RESET;
         modem_status_o[`MSR_CTS_BIT]  <= ~sync2_q.cts_n;
         modem_status_o[`MSR_DSR_BIT]  <= ~sync2_q.dsr_n;
         modem_status_o[`MSR_DCD_BIT]  <= ~sync2_q.dcd_n;
         modem_status_o[`MSR_DCTS_BIT] <= (msr_read_i ? 1'b0 : delta_q[0]) | change[0];
         modem_status_o[`MSR_DDSR_BIT] <= (msr_read_i ? 1'b0 : delta_q[1]) | change[1];
         modem_status_o[`MSR_DDCD_BIT] <= (msr_read_i ? 1'b0 : delta_q[2]) | change[2];
      end
   end

   // Interrupt: level from pending core sources and enabled modem deltas, the cts delta only outside auto mode; a status read clears the deltas
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= (|irq_src_i)
                  | (modem_irq_enable_i & ~auto_cts_enable_i & delta_q[0])
                  | (modem_irq_enable_i & (delta_q[1] | delta_q[2]))
                  ;
      end
   end

   // Transmitter gate from clear-to-send in auto mode
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         tx_enable_o <= 1'b1;
      end else begin
         tx_enable_o <= ~auto_cts_enable_i | ~sync2_q.cts_n;
      end
   end

   // Data bus drive; only a selected read turns drivers on
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         host_data_bus_o           <= 8'h00;
         host_data_bus_oe_n_o      <= 1'b1;
         transceiver_disable_out_o <= 1'b0;
      end else begin
         host_data_bus_o           <= read_data_i;
         host_data_bus_oe_n_o      <= ~(host_read_i & selected_o);
         transceiver_disable_out_o <= host_read_i & selected_o;
      end
   end

   // Modem control outputs, inactive high in loopback
   // Loopback forces all three inactive so a self test never signals the far end
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         dtr_n_o                <= 1'b1;
         user_output_first_n_o  <= 1'b1;
         user_output_second_n_o <= 1'b1;
      end else begin
         dtr_n_o <= modem_control_reg_i[`MCTL_LOOP_BIT]
                    | ~modem_control_reg_i[`MCTL_DTR_BIT];
         user_output_first_n_o <= modem_control_reg_i[`MCTL_LOOP_BIT]
                    | ~modem_control_reg_i[`MCTL_USER1_BIT];
         user_output_second_n_o <= modem_control_reg_i[`MCTL_LOOP_BIT]
                    | ~modem_control_reg_i[`MCTL_USER2_BIT];
      end
   end

   // host_data_bus_i is sampled by the register core, not here
   logic unused_bus;
   assign unused_bus = ^host_data_bus_i;

   // Checks watch registered outputs one edge after their cause, which is
   // the one-cycle answer the host side relies on
   // Sync stages are read directly so pin timing in a test cannot hide a fault
   // Modem control outputs
   chk_dtr_loop_high: assert property (
      @(posedge clk_i) disable iff (reset_i)
      modem_control_reg_i[`MCTL_LOOP_BIT] |=> dtr_n_o)
      else $error("dtr active in loopback");
   chk_dtr_set_low: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (modem_control_reg_i[`MCTL_DTR_BIT] && !modem_control_reg_i[`MCTL_LOOP_BIT]) |=> !dtr_n_o)
      else $error("dtr not driven active");
   chk_dtr_clear_high: assert property (
      @(posedge clk_i) disable iff (reset_i)
      !modem_control_reg_i[`MCTL_DTR_BIT] |=> dtr_n_o)
      else $error("dtr active with bit clear");
   chk_out_inactive: assert property (
      @(posedge clk_i) disable iff (reset_i)
      !modem_control_reg_i[`MCTL_USER1_BIT] |=> user_output_first_n_o)
      else $error("first user output active with bit clear");
   chk_user1_active: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (modem_control_reg_i[`MCTL_USER1_BIT] && !modem_control_reg_i[`MCTL_LOOP_BIT])
      |=> !user_output_first_n_o)
      else $error("first user output not driven active");
   chk_user2_active: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (modem_control_reg_i[`MCTL_USER2_BIT] && !modem_control_reg_i[`MCTL_LOOP_BIT])
      |=> !user_output_second_n_o)
      else $error("second user output not driven active");
   chk_user1_loop: assert property (
      @(posedge clk_i) disable iff (reset_i)
      modem_control_reg_i[`MCTL_LOOP_BIT] |=> user_output_first_n_o)
      else $error("first user output active in loopback");
   chk_user2_loop: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (modem_control_reg_i[`MCTL_LOOP_BIT] || !modem_control_reg_i[`MCTL_USER2_BIT])
      |=> user_output_second_n_o)
      else $error("second user output active when it must be inactive");

   // Modem status byte and change flags
   chk_cts_level: assert property (
      @(posedge clk_i) disable iff (reset_i)
      modem_status_o[`MSR_CTS_BIT] == !$past(sync2_q.cts_n))
      else $error("cts level mismatch");
   chk_dsr_level: assert property (
      @(posedge clk_i) disable iff (reset_i)
      modem_status_o[`MSR_DSR_BIT] == !$past(sync2_q.dsr_n))
      else $error("dsr level mismatch");
   chk_dcd_level: assert property (
      @(posedge clk_i) disable iff (reset_i)
      modem_status_o[`MSR_DCD_BIT] == !$past(sync2_q.dcd_n))
      else $error("dcd level mismatch");
   chk_cts_delta: assert property (
      @(posedge clk_i) disable iff (reset_i)
      $changed(sync2_q.cts_n) |=> modem_status_o[`MSR_DCTS_BIT])
      else $error("cts change not flagged");
   chk_dsr_delta: assert property (
      @(posedge clk_i) disable iff (reset_i)
      $changed(sync2_q.dsr_n) |=> modem_status_o[`MSR_DDSR_BIT])
      else $error("dsr change not flagged");
   chk_dcd_delta: assert property (
      @(posedge clk_i) disable iff (reset_i)
      $changed(sync2_q.dcd_n) |=> modem_status_o[`MSR_DDCD_BIT])
      else $error("dcd change not flagged");
   chk_delta_clear: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (msr_read_i && change == 3'b000) |=> delta_q == 3'b000)
      else $error("delta not cleared on read");

   // Host bus, driver disable and selection
   chk_drv_disable: assert property (
      @(posedge clk_i) disable iff (reset_i)
      !host_read_i |=> !transceiver_disable_out_o)
      else $error("driver disable not low");
   chk_bus_drive: assert property (
      @(posedge clk_i) disable iff (reset_i)
      !host_data_bus_oe_n_o |-> $past(host_read_i))
      else $error("bus driven outside read");
   chk_bus_data: assert property (
      @(posedge clk_i) disable iff (reset_i)
      !host_data_bus_oe_n_o |-> host_data_bus_o == $past(read_data_i))
      else $error("bus drives wrong byte");
   chk_sel_decode: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (!strobe2_q && !cs_sync2_q[2]) |=> !selected_o)
      else $error("selected with select low");
   chk_sel_held: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (strobe2_q && $past(strobe2_q)) |=> $stable(selected_o))
      else $error("selection changed while held");
   chk_sel_live: assert property (
      @(posedge clk_i) disable iff (reset_i)
      !strobe2_q |=> selected_o == $past(live_sel.sel))
      else $error("selection not following pins");

   // Interrupt and transmitter gate
   chk_irq_auto_cts: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (auto_cts_enable_i && irq_src_i == '0 && delta_q[2:1] == 2'b00) |=> !irq_o)
      else $error("cts irq in auto mode");
   chk_irq_pending: assert property (
      @(posedge clk_i) disable iff (reset_i)
      irq_src_i != '0 |=> irq_o)
      else $error("pending source without irq");
   chk_irq_modem: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (modem_irq_enable_i && delta_q[2:1] != 2'b00) |=> irq_o)
      else $error("modem change without irq");
   chk_irq_idle: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (irq_src_i == '0 && delta_q == 3'b000) |=> !irq_o)
      else $error("irq high with nothing pending");
   chk_tx_gate: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (auto_cts_enable_i && sync2_q.cts_n) |=> !tx_enable_o)
      else $error("transmitter not gated by cts");
endmodule

//--- verification/modem_model.sv
`timescale 1ns/1ps
module modem_model
   import uart_pins_pkg::*;
(
   input  wire logic         clk_i,
   input  wire modem_in_type want_i,
   output modem_in_type      pins_o
);
   // Data set moves its lines just after an edge; idle lines sit inactive high
   initial pins_o = 3'b111;
   always @(posedge clk_i) begin
      pins_o <= want_i;
   end
endmodule

//--- verification/testbench.sv
`timescale 1ns/1ps
module testbench;
   import uart_pins_pkg::*;
   typedef struct packed {
      logic [2:0]  cs;
      logic        rd;
      logic [7:0]  ctl;
      irq_src_type src;
      logic [6:0]  exp;
   } row_type;
   logic         clk_i, reset_i, strobe_n, host_read, msr_read, irq_en, auto_cts;
   logic [2:0]   cs, reg_addr, sel_addr;
   logic [7:0]   rdata, ctl, bus_out, status;
   irq_src_type  src;
   modem_in_type want, pins;
   logic         sel, oe_n, transceiver_disable_out, tx_en, irq, dtr_n, o1_n, o2_n;
   int           num_errors, cmp_count, cyc;
   int           lvl [3] = '{4, 5, 7};
   int           dlt [3] = '{0, 1, 3};
   // Expected: selected, disable, oe_n, dtr_n, user_output_first_n, user_output_second_n, irq
   row_type      rows [6] = '{
      '{3'b110, 1'b0, 8'h00, 4'h0, 7'b1011110},
      '{3'b110, 1'b1, 8'h0d, 4'h0, 7'b1100000},
      '{3'b010, 1'b1, 8'h01, 4'h8, 7'b0010111},
      '{3'b100, 1'b1, 8'h04, 4'h4, 7'b0011011},
      '{3'b111, 1'b1, 8'h08, 4'h2, 7'b0011101},
      '{3'b110, 1'b1, 8'h1d, 4'h1, 7'b1101111}};

   modem_model MODEM (.clk_i(clk_i), .want_i(want), .pins_o(pins));
   uart_host_modem_pins DUT (
      .clk_i(clk_i), .reset_i(reset_i), .unit_select_first_i(cs[2]),
      .unit_select_second_i(cs[1]), .unit_select_third_low_i(cs[0]),
      .address_latch_strobe_n_i(strobe_n), .reg_addr_i(reg_addr),
      .host_read_i(host_read), .msr_read_i(msr_read), .read_data_i(rdata),
      .host_data_bus_i(8'h00), .modem_control_reg_i(ctl), .modem_irq_enable_i(irq_en),
      .auto_cts_enable_i(auto_cts), .irq_src_i(src), .modem_in_i(pins),
      .selected_o(sel), .sel_addr_o(sel_addr), .host_data_bus_o(bus_out),
      .host_data_bus_oe_n_o(oe_n), .transceiver_disable_out_o(transceiver_disable_out),
      .modem_status_o(status), .tx_enable_o(tx_en), .irq_o(irq), .dtr_n_o(dtr_n),
      .user_output_first_n_o(o1_n), .user_output_second_n_o(o2_n));

   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   // Hang guard, far above the roughly 150 cycles the run needs
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 2000) begin
         num_errors++;
         end_sim();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   // One-cycle status read; must be entered just after a rising edge
   task automatic clear_deltas();
      msr_read <= 1'b1;
      tick(1);
      msr_read <= 1'b0;
      tick(3);
   endtask
   task automatic end_sim();
      if (num_errors == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      // Busy inputs during reset, so reset levels are really forced
      reset_i = 1'b1; strobe_n = 1'b0; cs = 3'b110; host_read = 1'b1; msr_read = 1'b0;
      ctl = 8'h0d; src = 4'hf; irq_en = 1'b1; auto_cts = 1'b0; want = 3'b111;
      rdata = 8'h3c; reg_addr = 3'h0;
      tick(5);
      #1;
      chk({1'b0, oe_n, dtr_n, o1_n, o2_n, irq, transceiver_disable_out, tx_en}, 8'h79);
      chk(status, 8'h00);
      tick(1);
      reset_i <= 1'b0;
      tick(4);
      clear_deltas();
      // Ordinary select, read and control cases
      for (int i = 0; i < 6; i++) begin
         {cs, host_read, ctl, src} <= {rows[i].cs, rows[i].rd, rows[i].ctl, rows[i].src};
         reg_addr <= i[2:0];
         rdata <= 8'ha0 + i[7:0];
         tick(5);
         #1;
         chk({1'b0, sel, transceiver_disable_out, oe_n, dtr_n, o1_n, o2_n, irq}, {1'b0, rows[i].exp});
         chk({5'h0, sel_addr}, {5'h0, i[2:0]});
         if (!rows[i].exp[4]) chk(bus_out, 8'ha0 + i[7:0]);
         tick(1);
      end
      // Strobe high holds the captured selection against changing inputs
      {cs, host_read, ctl, src} <= {3'b110, 1'b0, 8'h00, 4'h0};
      reg_addr <= 3'h5;
      tick(4);
      clear_deltas();
      strobe_n <= 1'b1;
      tick(4);
      cs <= 3'b000;
      reg_addr <= 3'h2;
      tick(4);
      #1;
      chk({4'h0, sel, sel_addr}, 8'h0d);
      tick(1);
      strobe_n <= 1'b0;
      tick(4);
      #1;
      chk({4'h0, sel, sel_addr}, 8'h02);
      // Each modem line: level, change flag, interrupt, read clears
      for (int k = 0; k < 3; k++) begin
         tick(1);
         want[k] <= 1'b0;
         tick(6);
         #1;
         chk({6'h0, status[lvl[k]], status[dlt[k]]}, 8'h03);
         chk({7'h0, irq}, 8'h01);
         tick(1);
         clear_deltas();
         #1;
         chk({6'h0, status[dlt[k]], irq}, 8'h00);
         tick(1);
         want[k] <= 1'b1;
         tick(6);
         clear_deltas();
      end
      // Auto flow mode: change is flagged but silent, line gates sending
      auto_cts <= 1'b1;
      want[0] <= 1'b0;
      tick(6);
      #1;
      chk({5'h0, status[0], irq, tx_en}, 8'h05);
      tick(1);
      want[0] <= 1'b1;
      tick(6);
      #1;
      chk({6'h0, irq, tx_en}, 8'h00);
      end_sim();
   end
endmodule
